// ==== src/iors_io_space.sv ====
/*
 * iors_io_space: 64-location I/O register space seen by the core, with
 * single-bit set, clear and test on the low 32 locations, flag clearing,
 * port pin control, reset generation and sleep clock gating.
 * Assumes the core issues at most one access per cycle and that event
 * inputs are one-cycle pulses on sys_clk_i.
 */
`timescale 1ns/1ps
module iors_io_space
   import iors_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // core access
   input wire logic [5:0] io_addr_i,
   input wire logic io_rd_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic set_single_bit_op_i,
   input wire logic clear_single_bit_op_i,
   input wire logic skip_if_bit_one_op_i,
   input wire logic skip_if_bit_zero_op_i,
   output logic [7:0] io_rdata_o,
   output logic skip_o,
   // peripheral events and levels
   input wire logic [2:0] timer_flag_evt_i,
   input wire logic [1:0] ext_flag_evt_i,
   input wire logic conv_done_evt_i,
   input wire logic cmp_evt_i,
   input wire logic wdog_evt_i,
   input wire logic cmp_level_i,
   input wire logic [15:0] conv_result_i,
   // sleep control
   input wire logic sleep_req_i,
   input wire logic wake_i,
   output logic cpu_clk_en_o,
   output logic io_clk_en_o,
   output logic conv_clk_en_o,
   output logic [1:0] sleep_state_o,
   // port pins
   input wire logic [5:0] gp_port_pins_i,
   output logic [5:0] gp_port_pins_o,
   output logic [5:0] gp_port_pins_oe_o,
   output logic [5:0] gp_pullup_en_o,
   // status flags to core
   output logic [7:0] core_status_flags_o
);

   ////////////////////////////////////////////////////////////////////
   // reset generation

   iors_rst_if rst ();
   logic core_rst_n;

   iors_rst_gen u_rst_gen (
      .sys_clk_i (sys_clk_i),
      .rst_n_i (rst_n_i),
      .rst (rst.gen)
   );

   assign core_rst_n = rst.rst_n_int;

   ////////////////////////////////////////////////////////////////////
   // declarations

   // register file
   logic [7:0] regs [IORS_NUM_REGS];
   logic [7:0] next_reg [IORS_NUM_REGS];
   logic [7:0] hw_set [IORS_NUM_REGS];

   // access decode
   logic [7:0] wr_sel;
   logic [7:0] wr_val;
   logic bit_op_ok;
   logic [7:0] rd_val;
   logic test_bit;
   logic skip_hit;

   // pins
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;

   // sleep
   iors_sleep_t sleep_state;
   iors_sleep_t next_sleep_state;
   logic sleep_en;
   logic [1:0] sleep_mode;
   logic io_run;
   logic conv_run;

   ////////////////////////////////////////////////////////////////////
   // pin input synchroniser

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
      end else begin
         pin_meta <= gp_port_pins_i;
         pin_sync <= pin_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write selection

   // bit operations only in low range
   assign bit_op_ok = (set_single_bit_op_i || clear_single_bit_op_i)
                      && (io_addr_i <= IORS_BIT_TOP);

   always_comb begin
      wr_sel = 8'h00;
      wr_val = 8'h00;
      if (io_wr_i) begin
         wr_sel = 8'hFF;
         wr_val = io_wdata_i;
      end else if (bit_op_ok) begin
         wr_sel = 8'h01 << bit_sel_i;
         wr_val = set_single_bit_op_i ? 8'hFF : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hardware flag sets

   always_comb begin
      for (int i = 0; i < IORS_NUM_REGS; i++) begin
         hw_set[i] = 8'h00;
      end
      if (io_run) begin
         hw_set[IORS_TMR_FLAGS][IORS_TMR_FLAG_LSB +: 3] = timer_flag_evt_i;
         hw_set[IORS_CMP_CTRL][IORS_CMP_EVT_BIT] = cmp_evt_i;
      end
      if (conv_run) begin
         hw_set[IORS_CONV_CTRL_A][IORS_CONV_DONE_BIT] = conv_done_evt_i;
      end
      hw_set[IORS_EXT_FLAGS][IORS_EXT_FLAG_LSB +: 2] = ext_flag_evt_i;
      hw_set[IORS_WDOG_CTRL][IORS_WDOG_EVT_BIT] = wdog_evt_i;
      hw_set[IORS_RST_CAUSE][IORS_EXT_RST_BIT] = rst.ext_rst_evt;
   end

   ////////////////////////////////////////////////////////////////////
   // register storage, one entry per location

   for (genvar a = 0; a < IORS_NUM_REGS; a++) begin : g_reg
      logic [7:0] rw_m;
      logic [7:0] clr_m;
      logic [7:0] lane;

      assign rw_m = iors_rw_mask(6'(a));
      assign clr_m = iors_w1c_mask(6'(a));
      assign lane = (io_addr_i == 6'(a)) ? wr_sel : 8'h00;

      assign next_reg[a] = (((regs[a] & ~(rw_m & lane)) | (wr_val & rw_m & lane))
                            & ~(clr_m & lane & wr_val)) | hw_set[a];

      always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
         if (!core_rst_n) begin
            regs[a] <= IORS_REG_RESET;
         end else begin
            regs[a] <= next_reg[a];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path

   always_comb begin
      rd_val = regs[io_addr_i] & (iors_rw_mask(io_addr_i) | iors_w1c_mask(io_addr_i));
      if (io_addr_i == IORS_CONV_RES_LO) begin
         rd_val = conv_result_i[7:0];
      end else if (io_addr_i == IORS_CONV_RES_HI) begin
         rd_val = conv_result_i[15:8];
      end else if (io_addr_i == IORS_PIN_LEVEL) begin
         rd_val = {2'h0, pin_sync};
      end else if (io_addr_i == IORS_CMP_CTRL) begin
         rd_val[IORS_CMP_OUT_BIT] = cmp_level_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data register

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i) begin
         io_rdata_o <= rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bit test

   assign test_bit = rd_val[bit_sel_i];
   assign skip_hit = (io_addr_i <= IORS_BIT_TOP)
                     && ((skip_if_bit_one_op_i && test_bit)
                         || (skip_if_bit_zero_op_i && !test_bit));

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         skip_o <= 1'b0;
      end else begin
         skip_o <= skip_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sleep control

   assign sleep_en = regs[IORS_CORE_CTRL][IORS_SLEEP_EN_BIT];
   assign sleep_mode = regs[IORS_CORE_CTRL][IORS_SLEEP_MODE_LSB +: 2];

   always_comb begin
      next_sleep_state = sleep_state;
      case (sleep_state)
         IORS_AWAKE: begin
            if (sleep_req_i && sleep_en) begin
               if (sleep_mode == IORS_SM_IDLE) begin
                  next_sleep_state = IORS_IDLE;
               end else if (sleep_mode == IORS_SM_CONV) begin
                  next_sleep_state = IORS_CONV_QUIET;
               end else if (sleep_mode == IORS_SM_DOWN) begin
                  next_sleep_state = IORS_POWER_DOWN;
               end
            end
         end
         IORS_IDLE, IORS_CONV_QUIET, IORS_POWER_DOWN: begin
            if (wake_i) begin
               next_sleep_state = IORS_AWAKE;
            end
         end
         default: begin
            next_sleep_state = IORS_AWAKE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // sleep state register

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         sleep_state <= IORS_AWAKE;
      end else begin
         sleep_state <= next_sleep_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // peripheral run gating

   assign io_run = (sleep_state == IORS_AWAKE) || (sleep_state == IORS_IDLE);
   assign conv_run = io_run || (sleep_state == IORS_CONV_QUIET);

   assign sleep_state_o = sleep_state;

   ////////////////////////////////////////////////////////////////////
   // clock enables, one flop per domain

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         cpu_clk_en_o <= 1'b1;
      end else begin
         cpu_clk_en_o <= (next_sleep_state == IORS_AWAKE);
      end
   end

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         io_clk_en_o <= 1'b1;
      end else begin
         io_clk_en_o <= (next_sleep_state == IORS_AWAKE)
                        || (next_sleep_state == IORS_IDLE);
      end
   end

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         conv_clk_en_o <= 1'b1;
      end else begin
         conv_clk_en_o <= (next_sleep_state != IORS_POWER_DOWN);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // port pins

   assign gp_port_pins_oe_o = regs[IORS_PIN_DIR][5:0];
   assign gp_port_pins_o = regs[IORS_PIN_LATCH][5:0];

   ////////////////////////////////////////////////////////////////////
   // pull-ups on undriven pins

   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         gp_pullup_en_o <= 6'h00;
      end else begin
         gp_pullup_en_o <= ~next_reg[IORS_PIN_DIR][5:0]
                           & next_reg[IORS_PIN_LATCH][5:0]
                           & {6{~next_reg[IORS_CORE_CTRL][IORS_PULL_DIS_BIT]}};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status flags

   assign core_status_flags_o = regs[IORS_STATUS];

endmodule : iors_io_space

// ==== src/iors_pkg.sv ====
/*
 * iors_pkg: offsets, field positions, reset values, masks, sleep states
 * and timing counts shared by the I/O register space block.
 * Assumes a 25 MHz system clock and a 6-bit I/O address from the core.
 */
package iors_pkg;

   ////////////////////////////////////////////////////////////////////
   // timing
   localparam int IORS_CLK_MHZ = 25;
   localparam int IORS_RST_HOLD_NS = 1000;
   localparam int IORS_RST_HOLD_CYC = (IORS_RST_HOLD_NS * IORS_CLK_MHZ + 999) / 1000;
   localparam int IORS_RST_CNT_W = 8;

   ////////////////////////////////////////////////////////////////////
   // address space
   localparam int IORS_NUM_REGS = 64;
   localparam logic [5:0] IORS_BIT_TOP = 6'h1F;
   localparam logic [5:0] IORS_CONV_CTRL_B = 6'h03;
   localparam logic [5:0] IORS_CONV_RES_LO = 6'h04;
   localparam logic [5:0] IORS_CONV_RES_HI = 6'h05;
   localparam logic [5:0] IORS_CONV_CTRL_A = 6'h06;
   localparam logic [5:0] IORS_CONV_INSEL = 6'h07;
   localparam logic [5:0] IORS_CMP_CTRL = 6'h08;
   localparam logic [5:0] IORS_DIG_IN_DIS = 6'h14;
   localparam logic [5:0] IORS_PIN_CHG_MASK = 6'h15;
   localparam logic [5:0] IORS_PIN_LEVEL = 6'h16;
   localparam logic [5:0] IORS_PIN_DIR = 6'h17;
   localparam logic [5:0] IORS_PIN_LATCH = 6'h18;
   localparam logic [5:0] IORS_NVM_CTRL = 6'h1C;
   localparam logic [5:0] IORS_NVM_DATA = 6'h1D;
   localparam logic [5:0] IORS_NVM_INDEX = 6'h1E;
   localparam logic [5:0] IORS_WDOG_CTRL = 6'h21;
   localparam logic [5:0] IORS_CLK_PRESCALE = 6'h26;
   localparam logic [5:0] IORS_TMR_SYNC = 6'h28;
   localparam logic [5:0] IORS_TMR_CMP_B = 6'h29;
   localparam logic [5:0] IORS_DBG_DATA = 6'h2E;
   localparam logic [5:0] IORS_TMR_CTRL_A = 6'h2F;
   localparam logic [5:0] IORS_OSC_TRIM = 6'h31;
   localparam logic [5:0] IORS_TMR_COUNT = 6'h32;
   localparam logic [5:0] IORS_TMR_CTRL_B = 6'h33;
   localparam logic [5:0] IORS_RST_CAUSE = 6'h34;
   localparam logic [5:0] IORS_CORE_CTRL = 6'h35;
   localparam logic [5:0] IORS_TMR_CMP_A = 6'h36;
   localparam logic [5:0] IORS_SELF_PROG = 6'h37;
   localparam logic [5:0] IORS_TMR_FLAGS = 6'h38;
   localparam logic [5:0] IORS_TMR_MASK = 6'h39;
   localparam logic [5:0] IORS_EXT_FLAGS = 6'h3A;
   localparam logic [5:0] IORS_EXT_MASK = 6'h3B;
   localparam logic [5:0] IORS_STACK_LO = 6'h3D;
   localparam logic [5:0] IORS_STATUS = 6'h3F;

   ////////////////////////////////////////////////////////////////////
   // field positions and reset value
   localparam logic [7:0] IORS_REG_RESET = 8'h00;
   localparam int IORS_CONV_DONE_BIT = 4;
   localparam int IORS_CMP_EVT_BIT = 4;
   localparam int IORS_CMP_OUT_BIT = 5;
   localparam int IORS_WDOG_EVT_BIT = 7;
   localparam int IORS_TMR_FLAG_LSB = 1;
   localparam int IORS_EXT_FLAG_LSB = 5;
   localparam int IORS_EXT_RST_BIT = 1;
   localparam int IORS_SLEEP_EN_BIT = 5;
   localparam int IORS_SLEEP_MODE_LSB = 3;
   localparam int IORS_PULL_DIS_BIT = 6;
   localparam logic [1:0] IORS_SM_IDLE = 2'h0;
   localparam logic [1:0] IORS_SM_CONV = 2'h1;
   localparam logic [1:0] IORS_SM_DOWN = 2'h2;

   typedef enum logic [1:0] {
      IORS_AWAKE = 2'b00,
      IORS_IDLE = 2'b01,
      IORS_CONV_QUIET = 2'b10,
      IORS_POWER_DOWN = 2'b11
   } iors_sleep_t;

   ////////////////////////////////////////////////////////////////////
   // plain read/write bits per address
   function automatic logic [7:0] iors_rw_mask(input logic [5:0] a);
      case (a)
         IORS_CONV_CTRL_B: iors_rw_mask = 8'h47;
         IORS_CONV_CTRL_A: iors_rw_mask = 8'hEF;
         IORS_CONV_INSEL: iors_rw_mask = 8'h63;
         IORS_CMP_CTRL: iors_rw_mask = 8'hCB;
         IORS_DIG_IN_DIS, IORS_PIN_CHG_MASK, IORS_PIN_DIR, IORS_PIN_LATCH,
         IORS_NVM_CTRL: iors_rw_mask = 8'h3F;
         IORS_NVM_DATA, IORS_NVM_INDEX, IORS_TMR_CMP_B, IORS_DBG_DATA,
         IORS_OSC_TRIM, IORS_TMR_COUNT, IORS_TMR_CMP_A, IORS_STACK_LO,
         IORS_STATUS: iors_rw_mask = 8'hFF;
         IORS_WDOG_CTRL: iors_rw_mask = 8'h7F;
         IORS_CLK_PRESCALE: iors_rw_mask = 8'h8F;
         IORS_TMR_SYNC: iors_rw_mask = 8'h81;
         IORS_TMR_CTRL_A: iors_rw_mask = 8'hF3;
         IORS_TMR_CTRL_B: iors_rw_mask = 8'hCF;
         IORS_RST_CAUSE: iors_rw_mask = 8'h0F;
         IORS_CORE_CTRL: iors_rw_mask = 8'h7B;
         IORS_SELF_PROG: iors_rw_mask = 8'h1F;
         IORS_TMR_MASK: iors_rw_mask = 8'h0E;
         IORS_EXT_MASK: iors_rw_mask = 8'h60;
         default: iors_rw_mask = 8'h00;
      endcase
   endfunction : iors_rw_mask

   // write-one-to-clear flag bits per address
   function automatic logic [7:0] iors_w1c_mask(input logic [5:0] a);
      case (a)
         IORS_CONV_CTRL_A: iors_w1c_mask = 8'h10;
         IORS_CMP_CTRL: iors_w1c_mask = 8'h10;
         IORS_WDOG_CTRL: iors_w1c_mask = 8'h80;
         IORS_TMR_FLAGS: iors_w1c_mask = 8'h0E;
         IORS_EXT_FLAGS: iors_w1c_mask = 8'h60;
         default: iors_w1c_mask = 8'h00;
      endcase
   endfunction : iors_w1c_mask

endpackage : iors_pkg

// ==== src/iors_rst_gen.sv ====
/*
 * iors_rst_gen: turns the reset pin into the internal reset.
 * Assertion is asynchronous; release is synchronised and then held for
 * a fixed number of clocks. Assumes sys_clk_i runs after the pin rises.
 */
`timescale 1ns/1ps
module iors_rst_gen
   import iors_pkg::*;
(
   // clock and reset pin
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // internal reset
   iors_rst_if.gen rst
);

   logic [1:0] rel_sync;
   logic [IORS_RST_CNT_W-1:0] hold_cnt;
   logic hold_done;

   assign hold_done = (hold_cnt == IORS_RST_CNT_W'(IORS_RST_HOLD_CYC - 1));

   ////////////////////////////////////////////////////////////////////
   // asynchronous assert, clocked release
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rel_sync <= 2'h0;
      end else begin
         rel_sync <= {rel_sync[0], 1'b1};
      end
   end

   // hold counter after release
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_cnt <= '0;
         rst.rst_n_int <= 1'b0;
         rst.ext_rst_evt <= 1'b0;
      end else begin
         rst.ext_rst_evt <= 1'b0;
         if (rel_sync[1] && !rst.rst_n_int) begin
            if (hold_done) begin
               rst.rst_n_int <= 1'b1;
               rst.ext_rst_evt <= 1'b1;
            end else begin
               hold_cnt <= hold_cnt + IORS_RST_CNT_W'(1);
            end
         end
      end
   end

endmodule : iors_rst_gen

// ==== src/iors_rst_if.sv ====
/*
 * iors_rst_if: internal reset and reset-event carrier between the reset
 * generator and the register space.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface iors_rst_if;
   logic rst_n_int;
   logic ext_rst_evt;
   modport gen (output rst_n_int, output ext_rst_evt);
   modport user (input rst_n_int, input ext_rst_evt);
endinterface : iors_rst_if

// ==== tb/iors_core_model.sv ====
/* iors_core_model: behavioural core issuing byte, bit and test accesses.
   Strobe vector is wr, rd, set, clr, test-one, test-zero; one per call. */
`timescale 1ns/1ps
module iors_core_model (
   // clock
   input wire logic sys_clk_i,
   // access
   output logic [5:0] io_addr_o,
   output logic [7:0] io_wdata_o,
   output logic [2:0] bit_sel_o,
   output logic [5:0] strobe_o
);
   localparam logic [63:0] CORE_MAPPED = 64'hAFFE_C342_71F0_01F8;
   initial begin
      io_addr_o = 6'h00;
      io_wdata_o = 8'h00;
      bit_sel_o = 3'h0;
      strobe_o = 6'h00;
   end
   task automatic issue(input logic [5:0] op, input logic [5:0] a, input logic [2:0] b,
      input logic [7:0] d);
      if ((op & 6'h2C) != 6'h00 && !CORE_MAPPED[a]) begin
         return;
      end
      @(posedge sys_clk_i);
      io_addr_o <= a;
      bit_sel_o <= b;
      io_wdata_o <= d;
      strobe_o <= op;
      @(posedge sys_clk_i);
      strobe_o <= 6'h00;
   endtask : issue
endmodule : iors_core_model

// ==== tb/iors_io_space_props.sv ====
/* iors_io_space_props: port-level assertions for the I/O register space.
   Bound into iors_io_space; one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
module iors_io_space_props
   import iors_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // core access
   input wire logic [5:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic set_single_bit_op_i,
   input wire logic clear_single_bit_op_i,
   input wire logic skip_if_bit_one_op_i,
   input wire logic skip_if_bit_zero_op_i,
   input wire logic skip_o,
   // sleep, pins, status
   input wire logic wake_i,
   input wire logic cpu_clk_en_o,
   input wire logic io_clk_en_o,
   input wire logic conv_clk_en_o,
   input wire logic [1:0] sleep_state_o,
   input wire logic [5:0] gp_port_pins_o,
   input wire logic [5:0] gp_port_pins_oe_o,
   input wire logic [7:0] core_status_flags_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] lane;
   logic test_any;
   logic bit_op;
   assign lane = 8'h01 << bit_sel_i;
   assign test_any = skip_if_bit_one_op_i | skip_if_bit_zero_op_i;
   assign bit_op = (set_single_bit_op_i | clear_single_bit_op_i) & ~io_wr_i;
   sequence high_test_s;
      test_any && io_addr_i > IORS_BIT_TOP;
   endsequence
   sequence down_wake_s;
      sleep_state_o == IORS_POWER_DOWN && wake_i;
   endsequence
   ////////////////////////////////////////////////////////////
   // pins float
   pins_float_a: assert property (disable iff (1'b0)
      !rst_n_i |-> gp_port_pins_oe_o == 6'h00) else $error("pins driven in reset");
   skip_cause_a: assert property (skip_o |->
      $past(test_any) && $past(io_addr_i) <= IORS_BIT_TOP) else $error("stray skip");
   skip_high_a: assert property (high_test_s |=> !skip_o)
      else $error("skip above bit range");
   dir_set_a: assert property (bit_op && set_single_bit_op_i && io_addr_i == IORS_PIN_DIR
      |=> gp_port_pins_oe_o == ($past(gp_port_pins_oe_o) | $past(lane[5:0])))
      else $error("set touched other bits");
   latch_clr_a: assert property (bit_op && clear_single_bit_op_i &&
      io_addr_i == IORS_PIN_LATCH |=> gp_port_pins_o == ($past(gp_port_pins_o) &
      ~$past(lane[5:0]))) else $error("clear touched other bits");
   high_bitop_a: assert property (bit_op && io_addr_i > IORS_BIT_TOP
      |=> $stable(core_status_flags_o)) else $error("bit op above range acted");
   status_wr_a: assert property (io_wr_i && io_addr_i == IORS_STATUS
      |=> core_status_flags_o == $past(io_wdata_i)) else $error("status write lost");
   idle_clk_a: assert property (sleep_state_o == IORS_IDLE |->
      !cpu_clk_en_o && io_clk_en_o && conv_clk_en_o) else $error("idle clock gating");
   quiet_clk_a: assert property (sleep_state_o == IORS_CONV_QUIET |->
      !cpu_clk_en_o && !io_clk_en_o && conv_clk_en_o) else $error("quiet clock gating");
   down_wake_a: assert property (down_wake_s |-> !conv_clk_en_o ##1
      sleep_state_o == IORS_AWAKE && cpu_clk_en_o) else $error("power-down wake");
endmodule : iors_io_space_props
bind iors_io_space iors_io_space_props i_iors_io_space_props (.sys_clk_i, .rst_n_i,
   .io_addr_i, .io_wr_i, .io_wdata_i, .bit_sel_i, .set_single_bit_op_i,
   .clear_single_bit_op_i, .skip_if_bit_one_op_i, .skip_if_bit_zero_op_i, .skip_o,
   .wake_i, .cpu_clk_en_o, .io_clk_en_o, .conv_clk_en_o, .sleep_state_o,
   .gp_port_pins_o, .gp_port_pins_oe_o, .core_status_flags_o);

// ==== tb/iors_io_space_tb_top.sv ====
/* iors_io_space_tb_top: self-checking bench of the I/O register space.
   The core model issues accesses; events, sleep and pins come from here. */
`timescale 1ns/1ps
module iors_io_space_tb_top;
   import iors_pkg::*;
   localparam logic [5:0] OP_SET = 6'h08;
   localparam logic [5:0] OP_CLR = 6'h04;
   localparam logic [5:0] OP_ONE = 6'h02;
   localparam logic [5:0] OP_ZERO = 6'h01;
   logic sys_clk_i, rst_n_i, skip_o, sleep_req_i, wake_i;
   logic conv_done_evt_i, cmp_evt_i, wdog_evt_i;
   logic cpu_clk_en_o, io_clk_en_o, conv_clk_en_o;
   logic [1:0] sleep_state_o, ext_flag_evt_i;
   logic [2:0] bit_sel_i, timer_flag_evt_i;
   logic [5:0] io_addr_i, strb, pin_ext, gp_port_pins_o, gp_port_pins_oe_o, gp_pullup_en_o;
   logic [7:0] io_wdata_i, io_rdata_o, core_status_flags_o;
   wire [5:0] gp_port_pins_i;
   int n_fail = 0;
   int samples_checked = 0;
   logic [5:0] ra [11] = '{6'h34, 6'h06, 6'h08, 6'h21, 6'h38, 6'h3A, 6'h04, 6'h05, 6'h00,
      6'h3E, 6'h16};
   logic [7:0] re [11] = '{8'h02, 8'h10, 8'h30, 8'h80, 8'h0E, 8'h60, 8'h34, 8'h12, 8'h00,
      8'h00, 8'h2A};
   logic [7:0] se [4] = '{8'h0B, 8'h11, 8'h18, 8'h07};
   logic [7:0] te [4] = '{8'h0E, 8'h00, 8'h00, 8'h0E};
   assign gp_port_pins_i = (gp_port_pins_oe_o & gp_port_pins_o) | (~gp_port_pins_oe_o & pin_ext);
   iors_io_space i_iors_io_space (.sys_clk_i, .rst_n_i, .io_addr_i, .io_rd_i(strb[4]),
      .io_wr_i(strb[5]), .io_wdata_i, .bit_sel_i, .set_single_bit_op_i(strb[3]),
      .clear_single_bit_op_i(strb[2]), .skip_if_bit_one_op_i(strb[1]),
      .skip_if_bit_zero_op_i(strb[0]), .io_rdata_o, .skip_o, .timer_flag_evt_i,
      .ext_flag_evt_i, .conv_done_evt_i, .cmp_evt_i, .wdog_evt_i, .cmp_level_i(1'b1),
      .conv_result_i(16'h1234), .sleep_req_i, .wake_i, .cpu_clk_en_o, .io_clk_en_o,
      .conv_clk_en_o, .sleep_state_o, .gp_port_pins_i, .gp_port_pins_o, .gp_port_pins_oe_o,
      .gp_pullup_en_o, .core_status_flags_o);
   iors_core_model i_iors_core_model (.sys_clk_i, .io_addr_o(io_addr_i),
      .io_wdata_o(io_wdata_i), .bit_sel_o(bit_sel_i), .strobe_o(strb));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string m, input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      i_iors_core_model.issue(6'h10, a, 3'h0, 8'h00);
      #1 chk("read", io_rdata_o, e);
   endtask : rd
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_iors_core_model.issue(6'h20, a, 3'h0, d);
   endtask : wr
   task automatic bop(input logic [5:0] op, input logic [5:0] a, input logic [2:0] b);
      i_iors_core_model.issue(op, a, b, 8'h00);
   endtask : bop
   task automatic tst(input logic [5:0] op, input logic [5:0] a, input logic [2:0] b,
      input logic e);
      i_iors_core_model.issue(op, a, b, 8'h00);
      #1 chk("skip", {7'h00, skip_o}, {7'h00, e});
   endtask : tst
   task automatic do_reset;
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      #1 chk("float", {2'h0, gp_port_pins_oe_o}, 8'h00);
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (30) @(posedge sys_clk_i);
   endtask : do_reset
   task automatic evt;
      @(posedge sys_clk_i);
      {timer_flag_evt_i, ext_flag_evt_i, conv_done_evt_i, cmp_evt_i, wdog_evt_i} <= 8'hFF;
      @(posedge sys_clk_i);
      {timer_flag_evt_i, ext_flag_evt_i, conv_done_evt_i, cmp_evt_i, wdog_evt_i} <= 8'h00;
   endtask : evt
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4000) @(posedge sys_clk_i);
      $display("FAIL %0t watchdog expired", $time);
      n_fail++;
      finish_test;
   end
   initial begin
      rst_n_i <= 1'b0;
      pin_ext <= 6'h2A;
      {timer_flag_evt_i, ext_flag_evt_i, conv_done_evt_i, cmp_evt_i, wdog_evt_i} <= 8'h00;
      sleep_req_i <= 1'b0;
      wake_i <= 1'b0;
      do_reset;
      evt;
      for (int i = 0; i < 11; i++) begin
         rd(ra[i], re[i]);
      end
      $display("test map done");
      wr(6'h06, 8'h00);
      rd(6'h06, 8'h10);
      wr(6'h38, 8'h02);
      rd(6'h38, 8'h0C);
      bop(OP_SET, 6'h06, 3'h0);
      bop(OP_CLR, 6'h06, 3'h4);
      rd(6'h06, 8'h11);
      tst(OP_ONE, 6'h06, 3'h0, 1'b1);
      tst(OP_ZERO, 6'h06, 3'h0, 1'b0);
      tst(OP_ZERO, 6'h06, 3'h1, 1'b1);
      tst(OP_ONE, 6'h06, 3'h4, 1'b1);
      bop(OP_SET, 6'h06, 3'h4);
      rd(6'h06, 8'h01);
      bop(OP_SET, 6'h08, 3'h4);
      rd(6'h08, 8'h20);
      bop(OP_CLR, 6'h06, 3'h0);
      rd(6'h06, 8'h00);
      $display("test flags done");
      wr(IORS_PIN_DIR, 8'h0F);
      wr(IORS_PIN_LATCH, 8'h3C);
      bop(OP_SET, IORS_PIN_DIR, 3'h5);
      bop(OP_CLR, IORS_PIN_LATCH, 3'h2);
      rd(IORS_PIN_DIR, 8'h2F);
      rd(IORS_PIN_LATCH, 8'h38);
      chk("oe", {2'h0, gp_port_pins_oe_o}, 8'h2F);
      chk("pull", {2'h0, gp_pullup_en_o}, 8'h10);
      wr(IORS_CORE_CTRL, 8'h40);
      #1 chk("pull", {2'h0, gp_pullup_en_o}, 8'h00);
      rd(IORS_PIN_LEVEL, 8'h28);
      $display("test port done");
      wr(IORS_STATUS, 8'hA5);
      bop(OP_SET, IORS_STATUS, 3'h1);
      bop(OP_CLR, IORS_STATUS, 3'h0);
      tst(OP_ONE, IORS_STATUS, 3'h0, 1'b0);
      rd(IORS_STATUS, 8'hA5);
      chk("status", core_status_flags_o, 8'hA5);
      $display("test status done");
      wr(6'h38, 8'h0E);
      for (int m = 0; m < 4; m++) begin
         wr(IORS_CORE_CTRL, {3'h1, m[1:0], 3'h0});
         @(posedge sys_clk_i);
         sleep_req_i <= 1'b1;
         @(posedge sys_clk_i);
         sleep_req_i <= 1'b0;
         timer_flag_evt_i <= 3'h7;
         #1 chk("sleep", {3'h0, sleep_state_o, cpu_clk_en_o, io_clk_en_o, conv_clk_en_o},
            se[m]);
         @(posedge sys_clk_i);
         timer_flag_evt_i <= 3'h0;
         wake_i <= 1'b1;
         @(posedge sys_clk_i);
         wake_i <= 1'b0;
         #1 chk("wake", {3'h0, sleep_state_o, cpu_clk_en_o, io_clk_en_o, conv_clk_en_o},
            8'h07);
         rd(6'h38, te[m]);
         wr(6'h38, 8'h0E);
      end
      rd(IORS_STATUS, 8'hA5);
      $display("test sleep done");
      do_reset;
      rd(IORS_PIN_DIR, 8'h00);
      rd(IORS_RST_CAUSE, 8'h02);
      $display("test reset done");
      finish_test;
   end
endmodule : iors_io_space_tb_top
